// ===== inc/qpd_regs.svh
// Purpose: Constants of the quad-pumped data phase agent.
// Assumes: Core clock 100 MHz, bus clock no faster than 125 ns period.
// Notes:   Pin levels are active low; reset values are pin levels.
`ifndef QPD_REGS_SVH
`define QPD_REGS_SVH
`define QPD_DATA_W       64
`define QPD_GROUPS       4
`define QPD_GROUP_W      16
`define QPD_INV_LIMIT    5'h08
`define QPD_BEATS        3'h4
`define QPD_FIFO_DEPTH   8
`define QPD_CLK_NS       10
`define QPD_BUSCLK_NS    125
`define QPD_SLOT_CYC     ((`QPD_BUSCLK_NS / `QPD_CLK_NS) / 4)
`define QPD_PIN_IDLE     1'h1
`define QPD_DATA_IDLE    64'hFFFFFFFFFFFFFFFF
`define QPD_NIB_IDLE     4'hF
`endif

// ===== inc/qpd_pkg.sv
// Purpose: Types of the quad-pumped data phase agent.
// Assumes: Included together with qpd_regs.svh.
// Notes:   Transmit states are one-hot.
package qpd_pkg;
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_OWN  = 4'h2,
        TX_REL  = 4'h4,
        TX_SPARE = 4'h8
    } qpd_tx_e;
    typedef logic [15:0] qpd_group_t;
    typedef logic [63:0] qpd_word_t;
endpackage

// ===== src/qpd_data_phase.sv
// Purpose: Data phase of a system-bus agent with quad-pumped 64-bit data.
// Assumes: Bus clock and all bus pins are asynchronous to clk.
// Notes:   Contract
`include "qpd_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module qpd_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output var  logic             inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady,
    output var  logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic             push;
    logic             pop;
    logic [AW:0]      countD;

    assign push     = inValid && inReady;
    assign pop      = outReady && outValid;
    assign outValid = count != '0;
    assign outData  = mem[rdPtr_q];
    assign countD   = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count   <= '0;
            inReady <= 1'b1;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count   <= countD;
            // Registered so the source sees full without a combinational path.
            inReady <= countD != DEPTH[AW:0];
        end
    end
endmodule

module qpd_data_phase (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                busClkIn,
    input  wire logic [63:0]         dataIn,
    output logic [63:0]              dataOut,
    output logic                     dataOe,
    input  wire logic [3:0]          strobePosPhaseIn,
    output logic [3:0]               strobePosPhaseOut,
    output logic                     strobePosPhaseOe,
    input  wire logic [3:0]          strobeNegPhaseIn,
    output logic [3:0]               strobeNegPhaseOut,
    output logic                     strobeNegPhaseOe,
    input  wire logic [3:0]          groupInvertFlagIn,
    output logic [3:0]               groupInvertFlagOut,
    output logic                     groupInvertFlagOe,
    input  wire logic                transferValidFlagIn,
    output logic                     transferValidFlagOut,
    output logic                     transferValidFlagOe,
    input  wire logic                dataBusOccupiedIn,
    output logic                     dataBusOccupiedOut,
    output logic                     dataBusOccupiedOe,
    input  wire qpd_pkg::qpd_word_t  txData,
    input  wire logic                txValid,
    output logic                     txReady,
    output qpd_pkg::qpd_word_t       rxData,
    output logic                     rxValid,
    output logic                     busOwned
);
    import qpd_pkg::*;

    localparam int NG = `QPD_GROUPS;
    localparam int GW = `QPD_GROUP_W;
    localparam logic [1:0] SLOT_LAST = 2'(`QPD_SLOT_CYC - 1);

    // Two-flop synchronisers on every pin read by the core clock.
    localparam int SW = 64 + 4 + 4 + 4 + 3;
    logic [SW-1:0] syncA_q;
    logic [SW-1:0] syncB_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_q <= '1;
            syncB_q <= '1;
        end else begin
            syncA_q <= {busClkIn, transferValidFlagIn, dataBusOccupiedIn,
                        groupInvertFlagIn, strobeNegPhaseIn,
                        strobePosPhaseIn, dataIn};
            syncB_q <= syncA_q;
        end
    end
    logic [63:0] dataS;
    logic [3:0]  strPS;
    logic [3:0]  strNS;
    logic [3:0]  invS;
    logic        occS;
    logic        validS;
    logic        busClkS;
    assign {busClkS, validS, occS, invS, strNS, strPS, dataS} = syncB_q;

    logic busClk_q;
    logic busRise;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busClk_q <= 1'b1;
        end else begin
            busClk_q <= busClkS;
        end
    end
    assign busRise = busClkS && !busClk_q;

    // Transmit FIFO; it fills when the bus is held by the partner.
    qpd_word_t   fifoData;
    logic        fifoValid;
    logic        fifoPop;
    logic [3:0]  fifoCount;
    qpd_fifo #(.WIDTH(`QPD_DATA_W), .DEPTH(`QPD_FIFO_DEPTH)) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inData   (txData),
        .inValid  (txValid),
        .inReady  (txReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .count    (fifoCount)
    );

    qpd_tx_e     txState_q;
    logic        burst_q;
    logic [1:0]  cyc_q;
    logic [2:0]  beat_q;
    logic        haveBeats;
    assign haveBeats = fifoCount >= {1'b0, `QPD_BEATS};
    assign fifoPop   = burst_q && cyc_q == 2'h0 && fifoValid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txState_q <= TX_IDLE;
        end else begin
            unique case (txState_q)
                TX_IDLE: begin
                    // Claim only after the partner has released the bus.
                    if (busRise && occS && validS && haveBeats) begin
                        txState_q <= TX_OWN;
                    end
                end
                TX_OWN: begin
                    if (busRise && !burst_q && fifoCount == 4'h0) begin
                        txState_q <= TX_REL;
                    end
                end
                TX_REL: begin
                    if (busRise) begin
                        txState_q <= TX_IDLE;
                    end
                end
                default: begin
                    txState_q <= TX_IDLE;
                end
            endcase
        end
    end

    // A burst is four beats of SLOT_CYC core cycles each inside one bus clock.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            burst_q <= 1'b0;
            cyc_q   <= 2'h0;
            beat_q  <= 3'h0;
        end else if (txState_q == TX_OWN && busRise && haveBeats) begin
            burst_q <= 1'b1;
            cyc_q   <= 2'h0;
            beat_q  <= 3'h0;
        end else if (burst_q) begin
            if (cyc_q == SLOT_LAST) begin
                cyc_q  <= 2'h0;
                beat_q <= beat_q + 3'h1;
                if (beat_q == `QPD_BEATS - 3'h1) begin
                    burst_q <= 1'b0;
                end
            end else begin
                cyc_q <= cyc_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            transferValidFlagOut <= `QPD_PIN_IDLE;
            dataBusOccupiedOut   <= `QPD_PIN_IDLE;
            dataOe               <= 1'b0;
            strobePosPhaseOe     <= 1'b0;
            strobeNegPhaseOe     <= 1'b0;
            groupInvertFlagOe    <= 1'b0;
            transferValidFlagOe  <= 1'b0;
            dataBusOccupiedOe    <= 1'b0;
            busOwned             <= 1'b0;
        end else begin
            busOwned <= txState_q != TX_IDLE;
            // All agent pins are driven together while the bus is ours.
            dataOe              <= txState_q != TX_IDLE;
            strobePosPhaseOe    <= txState_q != TX_IDLE;
            strobeNegPhaseOe    <= txState_q != TX_IDLE;
            groupInvertFlagOe   <= txState_q != TX_IDLE;
            transferValidFlagOe <= txState_q != TX_IDLE;
            dataBusOccupiedOe   <= txState_q != TX_IDLE;
            dataBusOccupiedOut  <= txState_q != TX_OWN;
            if (txState_q == TX_OWN && busRise) begin
                // Short of four words, this bus clock stays idle.
                transferValidFlagOut <= !haveBeats;
            end else if (txState_q != TX_OWN) begin
                transferValidFlagOut <= `QPD_PIN_IDLE;
            end
        end
    end

    // Per-group inversion and strobes.
    for (genvar g = 0; g < NG; g++) begin : g_tx
        qpd_group_t cand;
        logic [4:0] toggles;
        logic       flip;
        assign cand    = ~fifoData[g*GW +: GW];
        assign toggles = 5'($countones(cand ^ dataOut[g*GW +: GW]));
        assign flip    = toggles > `QPD_INV_LIMIT;

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                dataOut[g*GW +: GW]   <= qpd_group_t'(`QPD_DATA_IDLE >> 48);
                groupInvertFlagOut[g] <= `QPD_PIN_IDLE;
                strobePosPhaseOut[g]  <= `QPD_PIN_IDLE;
                strobeNegPhaseOut[g]  <= `QPD_PIN_IDLE;
            end else begin
                if (fifoPop) begin
                    dataOut[g*GW +: GW]   <= flip ? ~cand : cand;
                    groupInvertFlagOut[g] <= !flip;
                end
                // Even beats fall the positive strobe, odd beats the negative.
                if (burst_q && cyc_q == 2'h1) begin
                    strobePosPhaseOut[g] <= beat_q[0];
                    strobeNegPhaseOut[g] <= !beat_q[0];
                end else if (burst_q && cyc_q == 2'h2) begin
                    strobePosPhaseOut[g] <= 1'b1;
                    strobeNegPhaseOut[g] <= 1'b1;
                end
            end
        end
    end

    // Receive: each group captured by its own strobe falling edges.
    logic [3:0] strP_q;
    logic [3:0] strN_q;
    logic [3:0] pend_q;
    qpd_word_t  cap_q;
    logic       rxEn;
    logic [3:0] fall;
    assign rxEn = txState_q == TX_IDLE && !validS;
    assign fall = (strP_q & ~strPS) | (strN_q & ~strNS);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strP_q <= `QPD_NIB_IDLE;
            strN_q <= `QPD_NIB_IDLE;
        end else begin
            strP_q <= strPS;
            strN_q <= strNS;
        end
    end

    for (genvar g = 0; g < NG; g++) begin : g_rx
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                cap_q[g*GW +: GW] <= '0;
                pend_q[g]         <= 1'b0;
            end else if (rxEn && fall[g]) begin
                // Inverted groups arrive active high.
                cap_q[g*GW +: GW] <= invS[g] ? ~dataS[g*GW +: GW]
                                             : dataS[g*GW +: GW];
                pend_q[g]         <= 1'b1;
            end else if (&pend_q) begin
                pend_q[g] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxData  <= '0;
            rxValid <= 1'b0;
        end else begin
            rxValid <= &pend_q;
            if (&pend_q) begin
                rxData <= cap_q;
            end
        end
    end
endmodule

`default_nettype wire

// ===== tb/qpd_data_phase_monitor.sv
// Purpose: Checks on the pins of the data phase agent.
// Assumes: Pin levels are active low and idle high.
// Notes:   Beat spacing of three cycles comes from the slot length.
`timescale 1ns/1ns
`default_nettype none
module qpd_data_phase_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [63:0] dataOut,
    input wire logic        dataOe,
    input wire logic [3:0]  strobePosPhaseOut,
    input wire logic        strobePosPhaseOe,
    input wire logic [3:0]  strobeNegPhaseOut,
    input wire logic [3:0]  groupInvertFlagOut,
    input wire logic        groupInvertFlagOe,
    input wire logic        transferValidFlagOut,
    input wire logic        transferValidFlagOe,
    input wire logic        dataBusOccupiedOut,
    input wire logic        dataBusOccupiedOe,
    input wire logic        txReady,
    input wire logic        rxValid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [1:0] fallCnt_q;
    function automatic int maxTog(logic [63:0] a, logic [63:0] b);
        int m;
        m = 0;
        for (int g = 0; g < 4; g++) begin
            if ($countones(a[g*16+:16] ^ b[g*16+:16]) > m) begin
                m = $countones(a[g*16+:16] ^ b[g*16+:16]);
            end
        end
        return m;
    endfunction
    // Strobe falls of a burst counted modulo four.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fallCnt_q <= 2'h0;
        end else if ($fell(strobePosPhaseOut[0]) ||
                     $fell(strobeNegPhaseOut[0])) begin
            fallCnt_q <= fallCnt_q + 2'h1;
        end
    end
    property p_oe; dataOe |-> strobePosPhaseOe && groupInvertFlagOe &&
        transferValidFlagOe && dataBusOccupiedOe; endproperty
    a_oe: assert property (p_oe) else $error("enables split");
    property p_valid; $fell(strobePosPhaseOut[0]) |->
        !transferValidFlagOut && dataOe; endproperty
    a_valid: assert property (p_valid) else $error("strobe w/o valid");
    property p_quad; $rose(dataBusOccupiedOut) |-> fallCnt_q == 2'h0;
    endproperty
    a_quad: assert property (p_quad) else $error("partial burst");
    property p_alt; $fell(strobePosPhaseOut[0]) |->
        ##3 $fell(strobeNegPhaseOut[0]); endproperty
    a_alt: assert property (p_alt) else $error("strobes not alternating");
    property p_grp; strobePosPhaseOut inside {4'h0, 4'hF} &&
        strobeNegPhaseOut inside {4'h0, 4'hF}; endproperty
    a_grp: assert property (p_grp) else $error("group strobes differ");
    property p_stab; $fell(strobeNegPhaseOut[0]) |->
        $stable(dataOut) && $stable(groupInvertFlagOut); endproperty
    a_stab: assert property (p_stab) else $error("data moved at strobe");
    property p_tog; dataOe && $past(dataOe) |->
        maxTog(dataOut, $past(dataOut)) <= 8; endproperty
    a_tog: assert property (p_tog) else $error("too many toggles");
    property p_occ; $fell(strobePosPhaseOut[0]) |-> !dataBusOccupiedOut;
    endproperty
    a_occ: assert property (p_occ) else $error("bus not marked busy");
    property p_rel; $rose(dataBusOccupiedOut) |-> transferValidFlagOut;
    endproperty
    a_rel: assert property (p_rel) else $error("released while valid");
    c_burst: cover property ($fell(strobePosPhaseOut[0]));
    c_rx: cover property (rxValid);
    c_full: cover property ($fell(txReady));
endmodule
bind qpd_data_phase qpd_data_phase_monitor u_mon (.clk(clk), .rst(rst),
    .dataOut(dataOut), .dataOe(dataOe),
    .strobePosPhaseOut(strobePosPhaseOut),
    .strobePosPhaseOe(strobePosPhaseOe),
    .strobeNegPhaseOut(strobeNegPhaseOut),
    .groupInvertFlagOut(groupInvertFlagOut),
    .groupInvertFlagOe(groupInvertFlagOe),
    .transferValidFlagOut(transferValidFlagOut),
    .transferValidFlagOe(transferValidFlagOe),
    .dataBusOccupiedOut(dataBusOccupiedOut),
    .dataBusOccupiedOe(dataBusOccupiedOe),
    .txReady(txReady), .rxValid(rxValid));
`default_nettype wire

// ===== tb/qpd_peer_model.sv
// Purpose: Peer agent on the far side of the quad-pumped data bus.
// Assumes: Pull-ups on every pin, so a released pin reads high.
// Notes:   Bus clock runs free; beats are 31 ns apart.
`include "qpd_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module qpd_peer_model (
    output logic        busClk,
    input wire logic [63:0] dOut,
    input wire logic        dOe,
    input wire logic [3:0]  spOut,
    input wire logic        spOe,
    input wire logic [3:0]  snOut,
    input wire logic        snOe,
    input wire logic [3:0]  ivOut,
    input wire logic        ivOe,
    input wire logic        vOut,
    input wire logic        vOe,
    input wire logic        oOut,
    input wire logic        oOe,
    output logic [63:0] dBus,
    output logic [3:0]  spBus,
    output logic [3:0]  snBus,
    output logic [3:0]  ivBus,
    output logic        vBus,
    output logic        oBus,
    output logic [63:0] rxWord
);
    logic        pOe, pV, pO;
    logic [63:0] pD, rw;
    logic [3:0]  pSp, pSn, pIv, sp0, sn0, got;
    logic [63:0] txq[$];
    event        gotWord;
    // Both agents share every line; released lines float high.
    assign dBus  = dOe ? dOut : (pOe ? pD : `QPD_DATA_IDLE);
    assign spBus = spOe ? spOut : (pOe ? pSp : `QPD_NIB_IDLE);
    assign snBus = snOe ? snOut : (pOe ? pSn : `QPD_NIB_IDLE);
    assign ivBus = ivOe ? ivOut : (pOe ? pIv : `QPD_NIB_IDLE);
    assign vBus  = vOe ? vOut : (pOe ? pV : `QPD_PIN_IDLE);
    assign oBus  = oOe ? oOut : (pOe ? pO : `QPD_PIN_IDLE);
    initial begin
        pOe = 1'h0; pV = 1'h1; pO = 1'h1; pD = `QPD_DATA_IDLE;
        pSp = 4'hF; pSn = 4'hF; pIv = 4'hF; sp0 = 4'hF; sn0 = 4'hF;
        got = 4'h0;
        busClk = 1'h0;
        forever begin
            #63 busClk = 1'h1;
            #62 busClk = 1'h0;
        end
    end
    task automatic send();
        logic [63:0] w;
        logic [15:0] t;
        // The other agent may still drive its pins for one bus clock
        // after its occupied flag has gone high, so wait for it to let go.
        wait (oBus === 1'h1 && oOe === 1'h0 && dOe === 1'h0);
        @(posedge busClk);
        pOe = 1'h1;
        pO = 1'h0;
        while (txq.size() > 0) begin
            pV = 1'h0;
            for (int b = 0; b < 4; b++) begin
                w = txq.pop_front();
                for (int g = 0; g < 4; g++) begin
                    t = ~w[g*16+:16];
                    pIv[g] = $countones(t ^ pD[g*16+:16]) <= 8;
                    pD[g*16+:16] = pIv[g] ? t : ~t;
                end
                #8;
                if (b % 2 == 0) pSp = 4'h0; else pSn = 4'h0;
                #16;
                pSp = 4'hF;
                pSn = 4'hF;
                #7;
            end
            @(posedge busClk);
            pV = 1'h1;
            if (txq.size() > 0) @(posedge busClk);
        end
        pO = 1'h1;
        pOe = 1'h0;
    endtask
    // A word is complete once every group has seen a strobe fall.
    always @(spBus or snBus) begin
        for (int g = 0; g < 4; g++) begin
            if (!pOe && !vBus && ((sp0[g] && !spBus[g]) ||
                (sn0[g] && !snBus[g]))) begin
                rw[g*16+:16] = ivBus[g] ? ~dBus[g*16+:16] : dBus[g*16+:16];
                got[g] = 1'h1;
            end
        end
        sp0 = spBus;
        sn0 = snBus;
        if (&got) begin
            got = 4'h0;
            rxWord = rw;
            ->gotWord;
        end
    end
endmodule
`default_nettype wire

// ===== tb/qpd_data_phase_test.sv
// Purpose: Self-checking bench of the quad-pumped data phase agent.
// Assumes: Peer model resolves the shared pins.
// Notes:   Expected words are queued by the drivers.
`timescale 1ns/1ns
`default_nettype none
module qpd_data_phase_test;
    logic        clk, rst, busClk, txValid, txReady, rxValid, busOwned;
    logic [63:0] txData, rxData, dIn, dOut, peerWord;
    logic [3:0]  spIn, spOut, snIn, snOut, ivIn, ivOut;
    logic        dOe, spOe, snOe, ivOe, vIn, vOut, vOe, oIn, oOut, oOe;
    logic [63:0] txExp[$], rxExp[$], w;
    logic [63:0] pat[3] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF,
                            64'h00FF_00FF_01FF_01FF};
    int          errors, compares, n;
    logic [15:0] lf;
    qpd_data_phase u_dut (.clk(clk), .rst(rst), .busClkIn(busClk),
        .dataIn(dIn), .dataOut(dOut), .dataOe(dOe),
        .strobePosPhaseIn(spIn), .strobePosPhaseOut(spOut),
        .strobePosPhaseOe(spOe), .strobeNegPhaseIn(snIn),
        .strobeNegPhaseOut(snOut), .strobeNegPhaseOe(snOe),
        .groupInvertFlagIn(ivIn), .groupInvertFlagOut(ivOut),
        .groupInvertFlagOe(ivOe), .transferValidFlagIn(vIn),
        .transferValidFlagOut(vOut), .transferValidFlagOe(vOe),
        .dataBusOccupiedIn(oIn), .dataBusOccupiedOut(oOut),
        .dataBusOccupiedOe(oOe), .txData(txData), .txValid(txValid),
        .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
        .busOwned(busOwned));
    qpd_peer_model u_peer (.busClk(busClk), .dOut(dOut), .dOe(dOe),
        .spOut(spOut), .spOe(spOe), .snOut(snOut), .snOe(snOe),
        .ivOut(ivOut), .ivOe(ivOe), .vOut(vOut), .vOe(vOe), .oOut(oOut),
        .oOe(oOe), .dBus(dIn), .spBus(spIn), .snBus(snIn), .ivBus(ivIn),
        .vBus(vIn), .oBus(oIn), .rxWord(peerWord));
    function automatic logic [15:0] nextLf(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic cmp(logic [63:0] got, logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic take(ref logic [63:0] q[$], input logic [63:0] got);
        cmp(got, q.size() > 0 ? q.pop_front() : ~got);
    endtask
    // Boundary toggle patterns first, then pseudo-random words.
    task automatic word(int i, output logic [63:0] v);
        v = pat[i % 3];
        if (i >= 3) begin
            for (int k = 0; k < 4; k++) begin
                lf = nextLf(lf);
                v[k*16+:16] = lf;
            end
        end
    endtask
    task automatic pushN(int cnt, output int taken);
        logic [63:0] v;
        taken = 0;
        for (int i = 0; i < cnt; i++) begin
            word(i, v);
            @(negedge clk);
            txData = v;
            txValid = 1'h1;
            if (txReady === 1'h1) begin
                txExp.push_back(v);
                taken++;
            end
        end
        @(negedge clk);
        txValid = 1'h0;
    endtask
    task automatic drain();
        for (int k = 0; k < 3000 && txExp.size() + rxExp.size() > 0; k++) begin
            @(posedge clk);
        end
    endtask
    task automatic peerSend(int cnt);
        for (int i = 0; i < cnt; i++) begin
            word(i + 3, w);
            u_peer.txq.push_back(w);
            rxExp.push_back(w);
        end
        u_peer.send();
    endtask
    task automatic report_and_stop();
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(u_peer.gotWord) take(txExp, u_peer.rxWord);
    always @(posedge clk) begin
        if (rxValid === 1'h1) take(rxExp, rxData);
    end
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        errors++;
        report_and_stop();
    end
    initial begin
        rst = 1'h1; txValid = 1'h0; txData = 64'h0;
        errors = 0; compares = 0; lf = 16'hFB64;
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 1'h0;
        cmp({dOe, spOe, vOe, oOe, busOwned, rxValid, txReady}, 7'h01);
        fork
            peerSend(8);
        join_none
        wait (oIn === 1'h0);
        pushN(10, n);
        cmp(n, 8);
        cmp(busOwned, 1'h0);
        drain();
        pushN(5, n);
        repeat (80) @(posedge clk);
        cmp({busOwned, vOut, 6'(txExp.size())}, 8'hC1);
        pushN(3, n);
        drain();
        peerSend(4);
        drain();
        cmp(txExp.size() + rxExp.size(), 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
